/* verilog/ohb_host_bus.sv */
// Host bus front end: four link types into one byte stream
`timescale 1ns/10ps
module ohb_host_bus
(
  input  wire logic             clk_sys,      // System clock 40 MHz
  input  wire logic             rst_n,        // Async reset, active low
  input  wire logic             reset_in_n,   // Chip reset pin, active low
  input  wire logic             bus_select_low,  // Strap select bit 1
  input  wire logic             bus_select_high, // Strap select bit 2
  input  wire logic             cs_n,         // Chip select, active low
  input  wire logic             dc_sel,       // Data/command select
  input  wire logic             rw_wr,        // Direction or write strobe
  input  wire logic             en_rd,        // Enable or read strobe
  input  wire logic [7:0]       data_in,      // Data lines, input side
  output logic      [7:0]       data_out,     // Data lines, output side
  output logic      [7:0]       data_oe,      // Data lines, drive enable
  input  wire logic [7:0]       rd_value,     // Byte to return on reads
  output logic                  rd_strobe,    // Read taken pulse
  output ohb_pkg::ohb_byte_t    wr_byte,      // Received byte
  output logic                  wr_valid,     // Byte valid pulse
  output ohb_pkg::ohb_link_t    link_mode,    // Current link type
  output logic                  chip_init     // Chip initialise level
);

  // ******************************************************************
  // Input synchronisers, three stages
  // ******************************************************************
  localparam int NS = 13;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] s3_q;
  logic [NS-1:0] st_q;
  logic [NS-1:0] st_d;
  logic [NS-1:0] prev_q;

  assign pin_raw = {reset_in_n, cs_n, dc_sel, rw_wr, en_rd, data_in};

  always_comb
  begin
    st_d = st_q;
    for (int i = 0; i < NS; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        st_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      st_q   <= '1;
      prev_q <= '1;
    end
    else
    begin
      s1_q   <= pin_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      st_q   <= st_d;
      prev_q <= st_q;
    end
  end

  logic       rst_s;
  logic       cs_s;
  logic       dc_s;
  logic       rw_s;
  logic       en_s;
  logic [7:0] d_s;
  logic [7:0] d_p;
  logic       rw_p;
  logic       en_p;
  logic       sel;

  assign {rst_s, cs_s, dc_s, rw_s, en_s, d_s} = st_q;
  assign rw_p = prev_q[9];
  assign en_p = prev_q[8];
  assign d_p  = prev_q[7:0];

  assign chip_init = !rst_s;
  assign sel = !cs_s && rst_s;

  // ******************************************************************
  // Link selection
  // ******************************************************************
  ohb_pkg::ohb_link_t mode_q;
  ohb_pkg::ohb_link_t mode_d;
  logic               init_q;

  always_comb
  begin
    mode_d = mode_q;
    if (!init_q)
    begin
      case ({bus_select_low, bus_select_high})
        2'b10:   mode_d = ohb_pkg::OHB_LINK_I2C;
        2'b01:   mode_d = ohb_pkg::OHB_LINK_ENABLE;
        2'b11:   mode_d = ohb_pkg::OHB_LINK_SPLIT;
        default: mode_d = ohb_pkg::OHB_LINK_SERIAL;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= ohb_pkg::OHB_LINK_SERIAL;
      init_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      init_q <= rst_s;
    end
  end

  assign link_mode = mode_q;

  // ******************************************************************
  // Transfer engine
  // ******************************************************************
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  sda;
  logic                  i2c_start;
  logic                  i2c_stop;
  logic                  par_wr;
  logic                  par_rd;

  // line 0 clock, line 1 data
  // line 0 clock, line 1 data in
  assign scl_rise  = d_s[0] && !d_p[0];
  assign scl_fall  = !d_s[0] && d_p[0];
  assign sda       = d_s[1];
  assign i2c_start = d_s[0] && d_p[0] && !d_s[1] && d_p[1];
  assign i2c_stop  = d_s[0] && d_p[0] && d_s[1] && !d_p[1];

  always_comb
  begin
    par_wr = 1'b0;
    par_rd = 1'b0;
    if (mode_q == ohb_pkg::OHB_LINK_ENABLE)
    begin
      par_rd = en_s && !en_p && rw_s;
      par_wr = en_s && !en_p && !rw_s;
    end
    else if (mode_q == ohb_pkg::OHB_LINK_SPLIT)
    begin
      par_wr = !rw_s && rw_p;
      par_rd = !en_s && en_p;
    end
  end

  logic [7:0]           sh_q, sh_d;
  logic [3:0]           cnt_q, cnt_d;
  ohb_pkg::ohb_i2c_st_t ist_q, ist_d;
  logic                 ctl_q, ctl_d;
  logic                 ack_q, ack_d;
  ohb_pkg::ohb_byte_t   wb_q, wb_d;
  logic                 wv_q, wv_d;
  logic                 rv_q, rv_d;
  logic [7:0]           do_q, do_d;
  logic                 oe_q, oe_d;

  always_comb
  begin
    sh_d  = sh_q;
    cnt_d = cnt_q;
    ist_d = ist_q;
    ctl_d = ctl_q;
    ack_d = ack_q;
    wb_d  = wb_q;
    wv_d  = 1'b0;
    rv_d  = 1'b0;
    do_d  = do_q;
    oe_d  = oe_q;
    case (mode_q)
      ohb_pkg::OHB_LINK_SERIAL:
      begin
        oe_d = 1'b0;
        if (!sel)
        begin
          cnt_d = ohb_pkg::OHB_BIT_RESET;
        end
        else if (scl_rise)
        begin
          sh_d = {sh_q[6:0], sda};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == ohb_pkg::OHB_BIT_LAST)
          begin
            cnt_d = ohb_pkg::OHB_BIT_RESET;
            wb_d = '{is_data: dc_s, value: {sh_q[6:0], sda}};
            wv_d = 1'b1;
          end
        end
      end
      ohb_pkg::OHB_LINK_I2C:
      begin
        if (!rst_s || i2c_stop)
        begin
          ist_d = ohb_pkg::OHB_I2C_IDLE;
          ack_d = 1'b0;
        end
        else if (i2c_start)
        begin
          ist_d = ohb_pkg::OHB_I2C_ADDR;
          cnt_d = ohb_pkg::OHB_BIT_RESET;
          ack_d = 1'b0;
        end
        else if (scl_rise && ist_q != ohb_pkg::OHB_I2C_IDLE)
        begin
          if (cnt_q == ohb_pkg::OHB_BIT_ACK)
          begin
            cnt_d = ohb_pkg::OHB_BIT_RESET;
          end
          else
          begin
            sh_d  = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end
        end
        else if (scl_fall && ist_q != ohb_pkg::OHB_I2C_IDLE)
        begin
          if (cnt_q == ohb_pkg::OHB_BIT_ACK)
          begin
            ack_d = 1'b1;
            case (ist_q)
              ohb_pkg::OHB_I2C_ADDR:
              begin
                if (sh_q[7:1] != {ohb_pkg::OHB_I2C_ADDR_BASE, dc_s}
                    || sh_q[0])
                begin
                  ack_d = 1'b0;
                  ist_d = ohb_pkg::OHB_I2C_IDLE;
                end
                else
                begin
                  ist_d = ohb_pkg::OHB_I2C_CTRL;
                end
              end
              ohb_pkg::OHB_I2C_CTRL:
              begin
                ctl_d = sh_q[6];
                ist_d = ohb_pkg::OHB_I2C_DATA;
              end
              default:
              begin
                wb_d = '{is_data: ctl_q, value: sh_q};
                wv_d = 1'b1;
              end
            endcase
          end
          else
          begin
            ack_d = 1'b0;
          end
        end
        do_d = ohb_pkg::OHB_BYTE_RESET;
        oe_d = ack_q;
      end
      default:
      begin
        if (par_wr && sel)
        begin
          wb_d = '{is_data: dc_s, value: d_s};
          wv_d = 1'b1;
        end
        if (par_rd && sel)
        begin
          do_d = rd_value;
          rv_d = 1'b1;
        end
        if (mode_q == ohb_pkg::OHB_LINK_ENABLE)
        begin
          oe_d = sel && en_s && rw_s;
        end
        else
        begin
          oe_d = sel && !en_s;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_q  <= ohb_pkg::OHB_BYTE_RESET;
      cnt_q <= ohb_pkg::OHB_BIT_RESET;
      ist_q <= ohb_pkg::OHB_I2C_IDLE;
      ctl_q <= 1'b0;
      ack_q <= 1'b0;
      wb_q  <= '0;
      wv_q  <= 1'b0;
      rv_q  <= 1'b0;
      do_q  <= ohb_pkg::OHB_BYTE_RESET;
      oe_q  <= 1'b0;
    end
    else
    begin
      sh_q  <= sh_d;
      cnt_q <= cnt_d;
      ist_q <= ist_d;
      ctl_q <= ctl_d;
      ack_q <= ack_d;
      wb_q  <= wb_d;
      wv_q  <= wv_d;
      rv_q  <= rv_d;
      do_q  <= do_d;
      oe_q  <= oe_d;
    end
  end

  // ack pulls line 1, joined to 2
  assign data_out  = do_q;
  assign data_oe   = (mode_q == ohb_pkg::OHB_LINK_I2C) ?
                     {5'h00, oe_q, oe_q, 1'b0} : {8{oe_q}};
  assign wr_byte   = wb_q;
  assign wr_valid  = wv_q;
  assign rd_strobe = rv_q;

endmodule // ohb_host_bus

/* inc/ohb_pkg.sv */
// Package of constants and types for the display host bus interface
// Summary of operation
// - Two strapped select pins choose I2C, serial, enable-strobe or split-strobe link.
// - Bus activity counts only while chip select is low, except in I2C mode, which ignores chip select.
// - Low reset input initialises the chip; host keeps it high normally.
// - Data/command high marks the byte as display data.
// - Data/command low routes the byte to the command register.
// - In I2C mode data/command is the low target address bit.
// - Enable-strobe mode: direction high reads, low writes.
// - Enable-strobe mode: cycle starts when enable rises while selected.
// - Split-strobe mode: write starts when write strobe falls while selected.
// - Split-strobe mode: read starts when read strobe falls while selected.
// - Parallel modes use the eight data lines as a two-way bus.
// - Serial mode: line 0 is clock, line 1 data, line 2 unused.
// - I2C mode: lines 1 and 2 joined as data, line 0 clock.
package ohb_pkg;

  typedef enum logic [1:0]
  {
    OHB_LINK_SERIAL,
    OHB_LINK_I2C,
    OHB_LINK_ENABLE,
    OHB_LINK_SPLIT
  } ohb_link_t;

  typedef enum logic [1:0]
  {
    OHB_I2C_IDLE,
    OHB_I2C_ADDR,
    OHB_I2C_CTRL,
    OHB_I2C_DATA
  } ohb_i2c_st_t;

  typedef struct packed
  {
    logic       is_data;
    logic [7:0] value;
  } ohb_byte_t;

  localparam logic [5:0] OHB_I2C_ADDR_BASE = 6'h1e;
  localparam logic [3:0] OHB_BIT_LAST      = 4'h7;
  localparam logic [3:0] OHB_BIT_ACK       = 4'h8;
  localparam logic [3:0] OHB_BIT_RESET     = 4'h0;
  localparam logic [7:0] OHB_BYTE_RESET    = 8'h00;

endpackage

/* verif/ohb_host_bus_monitor.sv */
// Checker of host bus pin to pulse timing
`timescale 1ns/10ps
module ohb_host_bus_monitor
(
  input wire logic               clk_sys,    // Clock
  input wire logic               rst_n,      // Reset
  input wire logic               reset_in_n, // Chip reset
  input wire logic               cs_n,       // Select
  input wire logic               rw_wr,      // Strobe a
  input wire logic               en_rd,      // Strobe b
  input wire logic [7:0]         data_out,   // Read byte
  input wire logic [7:0]         data_oe,    // Drive
  input wire logic [7:0]         rd_value,   // Core byte
  input wire logic               rd_strobe,  // Read pulse
  input wire logic               wr_valid,   // Write pulse
  input wire ohb_pkg::ohb_link_t link_mode,  // Link
  input wire logic               chip_init   // Init
);
  logic en_m;
  logic sp_m;
  logic ds_m;
  assign en_m = !cs_n && !chip_init && link_mode == ohb_pkg::OHB_LINK_ENABLE;
  assign sp_m = !cs_n && !chip_init && link_mode == ohb_pkg::OHB_LINK_SPLIT;
  assign ds_m = cs_n && link_mode != ohb_pkg::OHB_LINK_I2C;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Pin to pulse checks
  // ****************************************
  a_init_on_pin: assert property ((!reset_in_n) [*6] |-> chip_init)
    else $error("chip init missing");
  a_deselect_quiet: assert property (ds_m [*8] |-> !wr_valid && !rd_strobe)
    else $error("pulse while deselected");
  a_enable_write: assert property
    ((en_m && !rw_wr && $rose(en_rd)) |-> ##[2:7] wr_valid)
    else $error("enable write lost");
  a_enable_read: assert property
    ((en_m && rw_wr && $rose(en_rd)) |-> ##[2:7] rd_strobe)
    else $error("enable read lost");
  a_split_write: assert property ((sp_m && $fell(rw_wr)) |-> ##[2:7] wr_valid)
    else $error("split write lost");
  a_split_read: assert property ((sp_m && $fell(en_rd)) |-> ##[2:7] rd_strobe)
    else $error("split read lost");
  a_read_data: assert property (rd_strobe |-> data_out == rd_value)
    else $error("read byte wrong");
  a_serial_no_drive: assert property
    (link_mode == ohb_pkg::OHB_LINK_SERIAL |-> data_oe == 8'h00)
    else $error("serial mode drives lines");
endmodule // ohb_host_bus_monitor

bind ohb_host_bus ohb_host_bus_monitor mon
(
  .clk_sys(clk_sys), .rst_n(rst_n), .reset_in_n(reset_in_n), .cs_n(cs_n),
  .rw_wr(rw_wr), .en_rd(en_rd), .data_out(data_out), .data_oe(data_oe),
  .rd_value(rd_value), .rd_strobe(rd_strobe), .wr_valid(wr_valid),
  .link_mode(link_mode), .chip_init(chip_init)
);

/* verif/ohb_host_model.sv */
// Host side model driving the display bus pins
`timescale 1ns/10ps
module ohb_host_model
(
  input  wire logic       clk_sys,  // Clock
  input  wire logic [7:0] data_out, // Device byte
  input  wire logic [7:0] data_oe,  // Device drive
  output logic            cs_n,     // Select
  output logic            dc_sel,   // Data/command
  output logic            rw_wr,    // Strobe a
  output logic            en_rd,    // Strobe b
  output logic      [7:0] data_in   // Resolved lines
);
  logic [7:0] drv_q = 8'h00;
  initial {cs_n, dc_sel, rw_wr, en_rd} = 4'h8;
  assign data_in = (data_oe & data_out) | (~data_oe & drv_q);
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // ****************************************
  // Transfers
  // ****************************************
  // strobe cycles
  task automatic par(input ohb_pkg::ohb_link_t m, input logic rd, dc, sel,
                     input logic [7:0] d, output logic [7:0] oe);
    logic en;
    en = m == ohb_pkg::OHB_LINK_ENABLE;
    cs_n <= !sel;
    dc_sel <= dc;
    drv_q <= rd ? ~drv_q : d;
    rw_wr <= en ? rd : 1'b1;
    en_rd <= !en;
    step(4);
    if (en)
      en_rd <= 1'b1;
    else if (rd)
      en_rd <= 1'b0;
    else
      rw_wr <= 1'b0;
    step(8);
    oe = data_oe;
    en_rd <= !en;
    rw_wr <= en ? rd : 1'b1;
    step(8);
    cs_n <= 1'b1;
    step(2);
  endtask
  // strobes low, clock line 0, MSB first
  task automatic ser(input logic dc, sel, input logic [7:0] d);
    rw_wr <= 1'b0;
    en_rd <= 1'b0;
    cs_n <= !sel;
    dc_sel <= dc;
    for (int i = 7; i >= 0; i--)
    begin
      drv_q <= {6'h00, d[i], 1'b0};
      step(4);
      drv_q[0] <= 1'b1;
      step(4);
    end
    drv_q <= {6'h00, ~d[0], 1'b0};
    step(8);
    cs_n <= 1'b1;
    step(2);
  endtask
  // address, control, data bytes; ack per byte
  task automatic i2c(input logic sa, input logic [23:0] f,
                     output logic [2:0] ack);
    rw_wr <= 1'b0;
    en_rd <= 1'b0;
    dc_sel <= sa;
    drv_q <= 8'h03;
    step(8);
    drv_q <= 8'h01;
    step(4);
    drv_q <= 8'h00;
    step(4);
    for (int k = 2; k >= 0; k--)
    begin
      for (int i = 7; i >= -1; i--)
      begin
        drv_q <= {6'h00, (i < 0) ? 1'b1 : f[8*k+i], 1'b0};
        step(4);
        drv_q[0] <= 1'b1;
        step(3);
        if (i < 0)
          ack[k] = !data_in[1];
        step(1);
        drv_q[0] <= 1'b0;
        step(4);
      end
    end
    drv_q <= 8'h00;
    step(4);
    drv_q <= 8'h01;
    step(4);
    drv_q <= 8'h03;
    step(8);
  endtask
endmodule // ohb_host_model

/* verif/tb.sv */
// Testbench of the host bus front end
`timescale 1ns/10ps
module tb;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               reset_in_n = 1'b0;
  logic               bus_select_low = 1'b0;
  logic               bus_select_high = 1'b0;
  logic [7:0]         rd_value = 8'h00;
  logic [7:0]         n_wr = 8'h00;
  logic [7:0]         n_rd = 8'h00;
  logic [7:0]         nw0;
  logic [2:0]         ack3;
  logic               cs_n, dc_sel, rw_wr, en_rd, rd_strobe, wr_valid;
  logic               chip_init;
  logic [7:0]         data_in, data_out, data_oe, got_rd;
  ohb_pkg::ohb_byte_t wr_byte, got_wr;
  ohb_pkg::ohb_link_t link_mode;
  int                 num_errors = 0;
  int                 checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  ohb_host_bus dut (.clk_sys(clk_sys), .rst_n(rst_n), .reset_in_n(reset_in_n),
    .bus_select_low(bus_select_low), .bus_select_high(bus_select_high),
    .cs_n(cs_n), .dc_sel(dc_sel), .rw_wr(rw_wr), .en_rd(en_rd),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .rd_value(rd_value), .rd_strobe(rd_strobe), .wr_byte(wr_byte),
    .wr_valid(wr_valid), .link_mode(link_mode), .chip_init(chip_init));
  ohb_host_model host (.clk_sys(clk_sys), .data_out(data_out),
    .data_oe(data_oe), .cs_n(cs_n), .dc_sel(dc_sel), .rw_wr(rw_wr),
    .en_rd(en_rd), .data_in(data_in));
  always @(posedge clk_sys)
  begin
    if (wr_valid === 1'b1)
      {n_wr, got_wr} <= {n_wr + 8'h01, wr_byte};
    if (rd_strobe === 1'b1)
      {n_rd, got_rd} <= {n_rd + 8'h01, data_out};
  end
  // ****************************************
  // Compare and closing tasks
  // ****************************************
  task automatic bad(input string s);
    num_errors++;
    $display("MISMATCH %0t %s", $time, s);
  endtask
  task automatic chk_u8(input logic [7:0] g, e);
    checks++;
    if (g !== e)
      bad($sformatf("value %h expected %h", g, e));
  endtask
  task automatic chk_byte(input ohb_pkg::ohb_byte_t g, e);
    checks++;
    if (g !== e)
      bad($sformatf("byte %h expected %h", g, e));
  endtask
  task automatic chk_mode(input ohb_pkg::ohb_link_t g, e);
    checks++;
    if (g !== e)
      bad("link type");
  endtask
  task automatic report_and_stop;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic strap(input logic [1:0] b);
    bus_select_low <= b[0];
    bus_select_high <= b[1];
    reset_in_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk_u8({7'h00, chip_init}, 8'h01);
    reset_in_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk_u8({7'h00, chip_init}, 8'h00);
    chk_mode(link_mode, ohb_pkg::ohb_link_t'(b));
  endtask
  task automatic xfer(input logic rd, dc, sel, input logic [7:0] d);
    logic [7:0] nw;
    logic [7:0] nr;
    logic [7:0] oe;
    nw = n_wr;
    nr = n_rd;
    oe = 8'h00;
    if (link_mode === ohb_pkg::OHB_LINK_SERIAL)
      host.ser(dc, sel, d);
    else
      host.par(link_mode, rd, dc, sel, d, oe);
    chk_u8(n_wr, nw + {7'h00, sel & !rd});
    chk_u8(n_rd, nr + {7'h00, sel & rd});
    if (sel && rd)
      chk_u8(got_rd, rd_value);
    if (sel && rd)
      chk_u8(oe, 8'hff);
    if (sel && !rd)
      chk_byte(got_wr, {dc, d});
    chk_u8(data_oe, 8'h00);
  endtask
  task automatic run_par;
    xfer(1'b0, 1'b0, 1'b1, 8'h3c);
    xfer(1'b0, 1'b1, 1'b1, 8'hc3);
    xfer(1'b0, 1'b1, 1'b0, 8'h11);
    xfer(1'b1, 1'b0, 1'b1, 8'h00);
    xfer(1'b1, 1'b0, 1'b0, 8'h00);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      strap(i[1:0]);
    strap(2'h2);
    rd_value <= 8'h5a;
    run_par;
    strap(2'h3);
    rd_value <= 8'ha5;
    run_par;
    strap(2'h0);
    xfer(1'b0, 1'b1, 1'b0, 8'hff);
    xfer(1'b0, 1'b0, 1'b1, 8'h96);
    xfer(1'b0, 1'b1, 1'b1, 8'h69);
    strap(2'h1);
    nw0 = n_wr;
    host.i2c(1'b0, 24'h78_40a7, ack3);
    chk_u8({5'h00, ack3}, 8'h07);
    chk_byte(got_wr, {1'b1, 8'ha7});
    chk_u8(n_wr, nw0 + 8'h01);
    chk_u8(data_oe, 8'h00);
    host.i2c(1'b1, 24'h78_40a7, ack3);
    chk_u8({5'h00, ack3}, 8'h00);
    chk_u8(n_wr, nw0 + 8'h01);
    report_and_stop;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    report_and_stop;
  end
endmodule // tb
